// ===== tb/bus_env_model.sv
// Access-condition model of the supporting-module bus and the external bus
`timescale 1ns/100ps
`default_nettype none
module bus_env_model (
  input wire logic mod16_cfg,
  input wire logic ext16_cfg,
  input wire logic ext3_cfg,
  input wire logic [2:0] wait_cfg,
  output logic mod_bus16,
  output logic ext_bus16,
  output logic ext_3state,
  output logic [state_count_pkg::WAIT_W-1:0] wait_m
);
  // ----------------------------------------------------------------
  // Bus widths and access mode
  // ----------------------------------------------------------------
  assign mod_bus16 = mod16_cfg;
  assign ext_bus16 = ext16_cfg;
  assign ext_3state = ext3_cfg;

  // ----------------------------------------------------------------
  // Wait insertion
  // ----------------------------------------------------------------
  // wait state count
  // Two-state external cycles never get wait states from the bus controller
  assign wait_m = ext3_cfg ? wait_cfg : 3'h0;
endmodule : bus_env_model
`default_nettype wire

// ===== tb/instruction_state_counter_tb.sv
// Self-checking bench for the instruction state counter
`timescale 1ns/100ps
`default_nettype none
module instruction_state_counter_tb;
  logic clk, rstn, start, busy_q, done_q;
  logic [4:0] instr;
  logic [1:0] code_rg, vect_rg, stack_rg, data_rg;
  logic m16, e16, e3;
  logic [2:0] wcfg;
  logic mod_bus16, ext_bus16, ext_3state;
  logic [state_count_pkg::WAIT_W-1:0] wait_m;
  logic [state_count_pkg::TOTAL_W-1:0] total_q;
  int err_count, comparisons;
  // Fetch, branch read, stack, byte, word, internal counts per instruction form
  int cnt [0:25][0:5] = '{'{1,0,0,0,0,0}, '{1,0,0,0,0,0}, '{2,0,0,0,0,0}, '{1,0,0,0,0,0}, '{3,0,0,0,0,0},
    '{1,0,0,0,0,0}, '{1,0,0,0,0,0}, '{1,0,0,0,0,0}, '{1,0,0,0,0,0}, '{1,0,0,0,0,0}, '{1,0,0,0,0,0},
    '{2,0,0,0,0,0}, '{1,0,0,0,0,0}, '{3,0,0,0,0,0}, '{2,0,0,0,0,0}, '{1,0,0,0,0,0}, '{2,0,0,0,0,0},
    '{1,0,0,0,0,0}, '{2,0,0,1,0,0}, '{2,0,0,1,0,0}, '{3,0,0,1,0,0}, '{4,0,0,1,0,0}, '{2,0,0,0,0,0},
    '{2,0,0,0,0,1}, '{2,0,0,2,0,0}, '{2,2,2,0,0,0}};

  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  bus_env_model u_env (.mod16_cfg(m16), .ext16_cfg(e16), .ext3_cfg(e3), .wait_cfg(wcfg),
    .mod_bus16(mod_bus16), .ext_bus16(ext_bus16), .ext_3state(ext_3state), .wait_m(wait_m));

  instruction_state_counter u_dut (.clk(clk), .rstn(rstn), .start(start), .instr(instr),
    .code_region(code_rg), .vect_region(vect_rg), .stack_region(stack_rg), .data_region(data_rg),
    .mod_bus16(mod_bus16), .ext_bus16(ext_bus16), .ext_3state(ext_3state), .wait_m(wait_m),
    .busy_q(busy_q), .done_q(done_q), .total_q(total_q));

  // ----------------------------------------------------------------
  // Expectations and compares
  // ----------------------------------------------------------------
  function automatic int cost(input int c, input logic [1:0] rg);
    if (c == 5 || rg == 2'h0) return 1;
    if (rg == 2'h1) return m16 ? 2 : (c == 3 ? 2 : 4);
    if (e16) return e3 ? 3 + int'(wcfg) : 2;
    if (e3) return c == 3 ? 3 + int'(wcfg) : 6 + 2 * int'(wcfg);
    return c == 3 ? 2 : 4;
  endfunction : cost

  function automatic logic [11:0] expect_total(input int ins);
    int sum;
    logic [1:0] rg;
    sum = 0;
    if (ins > 25) return 12'h000;
    for (int c = 0; c < 6; c++) begin
      rg = c == 0 ? code_rg : c == 1 ? vect_rg : c == 2 ? stack_rg : data_rg;
      sum += cnt[ins][c] * cost(c, rg);
    end
    return sum[11:0];
  endfunction : expect_total

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_total(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t total got %0d expected %0d", $time, got, exp);
    end
  endtask : chk_total

  // ----------------------------------------------------------------
  // Bus-cycle helpers
  // ----------------------------------------------------------------
  task automatic issue(input logic [4:0] ins);
    instr = ins;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask : issue

  task automatic watch(input logic [11:0] exp, input int first);
    for (int k = first; k < int'(state_count_pkg::RESULT_LATENCY); k++) begin
      chk_bit(busy_q, 1'b1);
      chk_bit(done_q, 1'b0);
      @(posedge clk);
      #1;
    end
    chk_bit(done_q, 1'b1);
    chk_bit(busy_q, 1'b0);
    chk_total(total_q, exp);
  endtask : watch

  // Gap 0 starts the next request in the done cycle
  task automatic run(input logic [4:0] ins, input logic [11:0] exp, input bit gap);
    issue(ins);
    watch(exp, 1);
    if (gap) begin
      @(posedge clk);
      #1;
    end
  endtask : run

  task automatic set_env(input logic [1:0] c, v, s, d, input logic [5:0] cfg);
    {code_rg, vect_rg, stack_rg, data_rg} = {c, v, s, d};
    {m16, e16, e3, wcfg} = cfg;
  endtask : set_env

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // every form, half of them back to back
  task automatic s_table;
    set_env(2'h0, 2'h2, 2'h1, 2'h2, 6'h0A);
    for (int i = 0; i < 26; i++) run(i[4:0], expect_total(i), i[0]);
    run(5'h1F, 12'h000, 1'b1);
  endtask : s_table

  // every bus shape, wait count and region
  task automatic s_costs;
    for (int cfg = 0; cfg < 64; cfg++) begin
      for (int r = 0; r < 4; r++) begin
        set_env(r[1:0], r[1:0], r[1:0], r == 0 ? 2'h1 : r[1:0], cfg[5:0]);
        run(state_count_pkg::INS_BAND_AA16, expect_total(20), 1'b1);
        run(state_count_pkg::INS_BCC_D16, expect_total(23), 1'b0);
        run(state_count_pkg::INS_CALL_MEM_IND, expect_total(25), 1'b1);
      end
    end
  endtask : s_costs

  // worked figures: 16-bit three-state external with one wait
  task automatic s_examples;
    set_env(2'h2, 2'h2, 2'h2, 2'h1, 6'h19);
    run(state_count_pkg::INS_BSET_AA8, 12'h00C, 1'b1);
    run(state_count_pkg::INS_CALL_MEM_IND, 12'h018, 1'b1);
  endtask : s_examples

  // A start while busy is dropped and inputs may move freely
  task automatic s_refused;
    logic [11:0] exp;
    set_env(2'h2, 2'h1, 2'h1, 2'h2, 6'h07);
    exp = expect_total(21);
    issue(state_count_pkg::INS_BAND_AA32);
    set_env(2'h0, 2'h0, 2'h0, 2'h0, 6'h38);
    issue(state_count_pkg::INS_CALL_MEM_IND);
    watch(exp, 2);
    @(posedge clk);
    #1;
    chk_bit(done_q, 1'b0);
    chk_total(total_q, exp);
  endtask : s_refused

  // Reset in mid-sum clears everything at once
  task automatic s_reset;
    issue(state_count_pkg::INS_CALL_MEM_IND);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    #1;
    chk_bit(busy_q, 1'b0);
    chk_bit(done_q, 1'b0);
    chk_total(total_q, 12'h000);
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    run(state_count_pkg::INS_ADD_L_IMM, expect_total(4), 1'b1);
  endtask : s_reset

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // About 6100 cycles are expected; the limit leaves wide margin
  initial begin
    #(100000 * 8);
    err_count++;
    stop_test();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    start = 1'b0;
    instr = 5'h00;
    set_env(2'h0, 2'h0, 2'h0, 2'h0, 6'h00);
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    s_table();
    s_costs();
    s_examples();
    s_refused();
    s_reset();
    stop_test();
  end
endmodule : instruction_state_counter_tb
`default_nettype wire

// ===== verilog/cycle_cost.sv
// States that one cycle of a given class costs in a given region
`timescale 1ns/100ps
`default_nettype none
module cycle_cost (
  input wire logic [2:0] cls,
  input wire logic [1:0] region,
  input wire logic mod_bus16,
  input wire logic ext_bus16,
  input wire logic ext_3state,
  input wire logic [state_count_pkg::WAIT_W-1:0] wait_m,
  output logic [state_count_pkg::COST_W-1:0] cost
);

  localparam int unsigned COST_W = state_count_pkg::COST_W;

  logic [state_count_pkg::COST_W-1:0] m_ext;
  logic [state_count_pkg::COST_W-1:0] one_3st;
  logic is_byte;
  logic is_word;

  assign m_ext = {2'h0, wait_m};
  assign one_3st = state_count_pkg::COST_3ST_BASE + m_ext;
  assign is_byte = (cls == state_count_pkg::CLS_BYTE);
  assign is_word = (cls == state_count_pkg::CLS_WORD);

  always_comb begin
    cost = state_count_pkg::COST_ONE;
    // RL3 internal is one
    if (cls == state_count_pkg::CLS_INTERNAL) begin
      cost = state_count_pkg::COST_ONE;
    // RL4 on-chip memory
    end else if (region == state_count_pkg::REG_ONCHIP_MEM) begin
      cost = state_count_pkg::COST_ONE;
    // RL5 supporting modules
    end else if (region == state_count_pkg::REG_MODULE) begin
      if (mod_bus16) begin
        cost = state_count_pkg::COST_BUS16_2ST;
      end else if (is_byte) begin
        cost = state_count_pkg::COST_BUS8_BYTE;
      end else begin
        cost = state_count_pkg::COST_BUS8_WORD;
      end
    // RL6 external devices, RL7 wait states
    end else if (ext_bus16) begin
      cost = ext_3state ? one_3st : state_count_pkg::COST_BUS16_2ST;
    end else if (is_byte) begin
      cost = ext_3state ? one_3st : state_count_pkg::COST_BUS8_BYTE;
    end else begin
      // Fetch, vector, stack and word all move two bytes on 8-bit bus
      cost = ext_3state ? COST_W'(one_3st << 1) : state_count_pkg::COST_BUS8_WORD;
    end
  end

endmodule : cycle_cost
`default_nettype wire

// ===== verilog/instruction_state_counter.sv
// Instruction execution-state counter: class counts times per-cycle cost
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: The total is the sum over six classes of cycle count times per-cycle cost.
// RL2: Each instruction form carries a fixed count for all six cycle classes.
// RL3: An internal operation cycle always costs one state.
// RL4: A fetch from on-chip memory costs one state.
// RL5: Module 8-bit bus costs fetch 4, byte 2, word 4; 16-bit module bus fetch costs 2.
// RL6: External 8-bit costs 4/2/4 two-state or 6+2m/3+m/6+2m three-state; 16-bit fetch 2 or 3+m.
// RL7: m is the wait-state count inserted in external accesses, zero when none.
// RL8: The memory-indirect subroutine call uses two fetch, two vector and two stack cycles only.
// RL9: Immediate arithmetic uses one, two or three fetches for 8, 16, 32-bit immediates.
module instruction_state_counter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [4:0] instr,
  input wire logic [1:0] code_region,
  input wire logic [1:0] vect_region,
  input wire logic [1:0] stack_region,
  input wire logic [1:0] data_region,
  input wire logic mod_bus16,
  input wire logic ext_bus16,
  input wire logic ext_3state,
  input wire logic [state_count_pkg::WAIT_W-1:0] wait_m,
  output logic busy_q,
  output logic done_q,
  output logic [state_count_pkg::TOTAL_W-1:0] total_q
);

  localparam int unsigned CW = state_count_pkg::CNT_W;
  localparam int unsigned TW = state_count_pkg::TOTAL_W;

  typedef logic [6*CW-1:0] counts_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC = 3'b010,
    ST_DONE = 3'b100
  } state_e;

  // ----------------------------------------------------------------
  // Cycle count table, packed {N,M,L,K,J,I}
  // ----------------------------------------------------------------
  function automatic counts_t pack6(input int i, input int j, input int k,
                                    input int l, input int m, input int n);
    pack6 = {CW'(n), CW'(m), CW'(l), CW'(k), CW'(j), CW'(i)};
  endfunction : pack6

  function automatic counts_t decode_counts(input logic [4:0] code);
    decode_counts = '0;
    // RL2 fixed class counts
    unique case (code)
      // RL9 immediate widths
      state_count_pkg::INS_ADD_B_IMM, state_count_pkg::INS_AND_B_IMM,
      state_count_pkg::INS_ADDX_IMM: decode_counts = pack6(1, 0, 0, 0, 0, 0);
      state_count_pkg::INS_ADD_W_IMM,
      state_count_pkg::INS_AND_W_IMM: decode_counts = pack6(2, 0, 0, 0, 0, 0);
      state_count_pkg::INS_ADD_L_IMM,
      state_count_pkg::INS_AND_L_IMM: decode_counts = pack6(3, 0, 0, 0, 0, 0);
      state_count_pkg::INS_ADD_B_REG, state_count_pkg::INS_ADD_W_REG,
      state_count_pkg::INS_ADD_L_REG, state_count_pkg::INS_ADDS,
      state_count_pkg::INS_ADDX_REG, state_count_pkg::INS_AND_B_REG,
      state_count_pkg::INS_AND_W_REG, state_count_pkg::INS_ANDC_FLAGS,
      state_count_pkg::INS_BAND_REG: decode_counts = pack6(1, 0, 0, 0, 0, 0);
      state_count_pkg::INS_AND_L_REG, state_count_pkg::INS_ANDC_EXT,
      state_count_pkg::INS_BCC_D8: decode_counts = pack6(2, 0, 0, 0, 0, 0);
      state_count_pkg::INS_BAND_IND,
      state_count_pkg::INS_BAND_AA8: decode_counts = pack6(2, 0, 0, 1, 0, 0);
      state_count_pkg::INS_BAND_AA16: decode_counts = pack6(3, 0, 0, 1, 0, 0);
      state_count_pkg::INS_BAND_AA32: decode_counts = pack6(4, 0, 0, 1, 0, 0);
      state_count_pkg::INS_BCC_D16: decode_counts = pack6(2, 0, 0, 0, 0, 1);
      state_count_pkg::INS_BSET_AA8: decode_counts = pack6(2, 0, 0, 2, 0, 0);
      // RL8 indirect call
      state_count_pkg::INS_CALL_MEM_IND: decode_counts = pack6(2, 2, 2, 0, 0, 0);
      // Unlisted codes cost nothing rather than stalling the caller
      default: decode_counts = '0;
    endcase
  endfunction : decode_counts

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  state_e state_q;
  counts_t cnt_q;
  logic [2:0] idx_q;
  logic [7:0] rgn_q;
  logic [5:0] cfg_q;
  logic [TW-1:0] acc_q;
  logic [1:0] cur_region;
  logic [state_count_pkg::COST_W-1:0] cur_cost;
  logic [CW-1:0] cur_cnt;
  logic [TW-1:0] term;

  // Config is latched so the result reflects the request, not later pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      rgn_q <= 8'h00;
      cfg_q <= 6'h00;
    end else if (start && state_q != ST_ACC) begin
      cnt_q <= decode_counts(instr);
      rgn_q <= {data_region, stack_region, vect_region, code_region};
      cfg_q <= {wait_m, ext_3state, ext_bus16, mod_bus16};
    end
  end

  // ----------------------------------------------------------------
  // Per-class cost and accumulation
  // ----------------------------------------------------------------
  always_comb begin
    unique case (idx_q)
      state_count_pkg::CLS_FETCH: cur_region = rgn_q[1:0];
      state_count_pkg::CLS_BRANCH: cur_region = rgn_q[3:2];
      state_count_pkg::CLS_STACK: cur_region = rgn_q[5:4];
      default: cur_region = rgn_q[7:6];
    endcase
  end

  assign cur_cnt = cnt_q[idx_q*CW +: CW];

  cycle_cost u_cost (
    .cls(idx_q),
    .region(cur_region),
    .mod_bus16(cfg_q[0]),
    .ext_bus16(cfg_q[1]),
    .ext_3state(cfg_q[2]),
    .wait_m(cfg_q[5:3]),
    .cost(cur_cost)
  );

  // RL1 count times cost
  assign term = TW'(cur_cnt) * TW'(cur_cost);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
      acc_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start) begin
            state_q <= ST_ACC;
            idx_q <= 3'h0;
            acc_q <= '0;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_ACC: begin
          // RL1 sum of products
          acc_q <= acc_q + term;
          if (idx_q == state_count_pkg::CLS_INTERNAL) begin
            state_q <= ST_DONE;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      total_q <= '0;
    end else begin
      busy_q <= (state_q == ST_ACC) ? (idx_q != state_count_pkg::CLS_INTERNAL)
                                     : (start && state_q != ST_ACC);
      done_q <= (state_q == ST_ACC) && (idx_q == state_count_pkg::CLS_INTERNAL);
      if (state_q == ST_ACC && idx_q == state_count_pkg::CLS_INTERNAL) begin
        total_q <= acc_q + term;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_take;
    start && state_q != ST_ACC;
  endsequence

  sequence s_run;
    busy_q [*6] ##1 done_q;
  endsequence

  property p_latency;
    @(posedge clk) disable iff (!rstn) s_take |=> s_run;
  endproperty
  a_latency: assert property (p_latency) else $error("result not ready seven cycles after start"); // RL1

  property p_total;
    @(posedge clk) disable iff (!rstn)
      done_q |-> total_q == $past(acc_q) + $past(term);
  endproperty
  a_total: assert property (p_total) else $error("total is not the sum of products"); // RL1

  property p_counts_fixed;
    @(posedge clk) disable iff (!rstn) (state_q == ST_ACC) |=> $stable(cnt_q) || state_q != ST_ACC;
  endproperty
  a_counts_fixed: assert property (p_counts_fixed) else $error("class counts changed mid-sum"); // RL2

  property p_internal_one;
    @(posedge clk) disable iff (!rstn)
      (idx_q == state_count_pkg::CLS_INTERNAL) |-> cur_cost == state_count_pkg::COST_ONE;
  endproperty
  a_internal_one: assert property (p_internal_one) else $error("internal cycle not one state"); // RL3

  property p_onchip_fetch;
    @(posedge clk) disable iff (!rstn)
      (idx_q == state_count_pkg::CLS_FETCH && cur_region == state_count_pkg::REG_ONCHIP_MEM)
        |-> cur_cost == 5'h01;
  endproperty
  a_onchip_fetch: assert property (p_onchip_fetch) else $error("on-chip fetch not one state"); // RL4

  property p_module8;
    @(posedge clk) disable iff (!rstn)
      (cur_region == state_count_pkg::REG_MODULE && !cfg_q[0] && idx_q != state_count_pkg::CLS_INTERNAL)
        |-> cur_cost == ((idx_q == state_count_pkg::CLS_BYTE) ? 5'h02 : 5'h04);
  endproperty
  a_module8: assert property (p_module8) else $error("8-bit module cost wrong"); // RL5

  property p_ext3;
    @(posedge clk) disable iff (!rstn)
      (cur_region == state_count_pkg::REG_EXTERNAL && cfg_q[2] && !cfg_q[1]
        && idx_q == state_count_pkg::CLS_FETCH) |-> cur_cost == 5'h06 + {1'h0, cfg_q[5:3], 1'h0};
  endproperty
  a_ext3: assert property (p_ext3) else $error("external three-state fetch cost wrong"); // RL6

  property p_wait_zero;
    @(posedge clk) disable iff (!rstn)
      (cur_region == state_count_pkg::REG_EXTERNAL && cfg_q[2] && cfg_q[5:3] == 3'h0
        && idx_q == state_count_pkg::CLS_BYTE) |-> cur_cost == 5'h03;
  endproperty
  a_wait_zero: assert property (p_wait_zero) else $error("no-wait byte access not three states"); // RL7

  property p_call;
    @(posedge clk) disable iff (!rstn)
      (s_take and instr == state_count_pkg::INS_CALL_MEM_IND) |=> cnt_q == pack6(2, 2, 2, 0, 0, 0);
  endproperty
  a_call: assert property (p_call) else $error("indirect call counts wrong"); // RL8

  property p_imm;
    @(posedge clk) disable iff (!rstn)
      (s_take and instr == state_count_pkg::INS_ADD_L_IMM) |=> cnt_q == pack6(3, 0, 0, 0, 0, 0);
  endproperty
  a_imm: assert property (p_imm) else $error("32-bit immediate counts wrong"); // RL9

endmodule : instruction_state_counter
`default_nettype wire

// ===== verilog/state_count_pkg.sv
// Shared constants and types for the instruction state counter
package state_count_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 3;
  localparam int unsigned COST_W = 5;
  localparam int unsigned TOTAL_W = 12;
  localparam int unsigned WAIT_W = 3;
  localparam int unsigned NUM_CLASS = 6;

  // ----------------------------------------------------------------
  // Cycle classes, in accumulation order
  // ----------------------------------------------------------------
  localparam logic [2:0] CLS_FETCH = 3'h0;
  localparam logic [2:0] CLS_BRANCH = 3'h1;
  localparam logic [2:0] CLS_STACK = 3'h2;
  localparam logic [2:0] CLS_BYTE = 3'h3;
  localparam logic [2:0] CLS_WORD = 3'h4;
  localparam logic [2:0] CLS_INTERNAL = 3'h5;

  // ----------------------------------------------------------------
  // Access regions
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_ONCHIP_MEM = 2'h0;
  localparam logic [1:0] REG_MODULE = 2'h1;
  localparam logic [1:0] REG_EXTERNAL = 2'h2;

  // ----------------------------------------------------------------
  // States per cycle
  // ----------------------------------------------------------------
  localparam logic [COST_W-1:0] COST_ONE = 5'h01;
  localparam logic [COST_W-1:0] COST_BUS8_BYTE = 5'h02;
  localparam logic [COST_W-1:0] COST_BUS8_WORD = 5'h04;
  localparam logic [COST_W-1:0] COST_BUS16_2ST = 5'h02;
  localparam logic [COST_W-1:0] COST_3ST_BASE = 5'h03;

  // ----------------------------------------------------------------
  // Instruction forms whose cycle counts are held
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    INS_ADD_B_IMM = 5'h00, INS_ADD_B_REG = 5'h01, INS_ADD_W_IMM = 5'h02,
    INS_ADD_W_REG = 5'h03, INS_ADD_L_IMM = 5'h04, INS_ADD_L_REG = 5'h05,
    INS_ADDS = 5'h06, INS_ADDX_IMM = 5'h07, INS_ADDX_REG = 5'h08,
    INS_AND_B_IMM = 5'h09, INS_AND_B_REG = 5'h0A, INS_AND_W_IMM = 5'h0B,
    INS_AND_W_REG = 5'h0C, INS_AND_L_IMM = 5'h0D, INS_AND_L_REG = 5'h0E,
    INS_ANDC_FLAGS = 5'h0F, INS_ANDC_EXT = 5'h10, INS_BAND_REG = 5'h11,
    INS_BAND_IND = 5'h12, INS_BAND_AA8 = 5'h13, INS_BAND_AA16 = 5'h14,
    INS_BAND_AA32 = 5'h15, INS_BCC_D8 = 5'h16, INS_BCC_D16 = 5'h17,
    INS_BSET_AA8 = 5'h18, INS_CALL_MEM_IND = 5'h19
  } instr_e;

  // Sequencer timing: start edge, then one class per cycle
  localparam int unsigned RESULT_LATENCY = 7;

endpackage : state_count_pkg
